// >>> hdl/backplane_bus_master_port.sv
// Backplane bus master port: cycle engine, arbiter, chain sources
module backplane_bus_master_port
  import bpbus_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC   // Reply limit in cycles
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Core request side
  input wire logic req_valid_in,
  input wire bpbus_pkg::cycle_kind_e req_kind_in,
  input wire logic [bpbus_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [bpbus_pkg::DATA_W-1:0] req_wdata_in,
  input wire logic req_byte_hi_in,
  input wire logic req_last_in,
  output logic req_ready_out,
  output logic rdata_valid_out,
  output logic [bpbus_pkg::DATA_W-1:0] rdata_out,
  output logic done_out,
  output logic timeout_err_out,
  output logic irq_pending_out,
  // Multiplexed address/data, active low, three-signal form
  input wire logic [bpbus_pkg::ADDR_W-1:0] mux_addr_data_line_n_in,
  output logic [bpbus_pkg::ADDR_W-1:0] mux_addr_data_line_n_out,
  output logic [bpbus_pkg::ADDR_W-1:0] mux_addr_data_line_oe_out,
  // Transfer control, driven by the master; reply received from the slave
  output logic cycle_sync_n_out,
  output logic cycle_sync_oe_out,
  output logic data_in_strobe_n_out,
  output logic data_in_strobe_oe_out,
  output logic data_out_strobe_n_out,
  output logic data_out_strobe_oe_out,
  output logic write_byte_flag_n_out,
  output logic write_byte_flag_oe_out,
  output logic io_page_select_n_out,
  output logic io_page_select_oe_out,
  output logic refresh_or_block_flag_n_out,
  output logic refresh_or_block_flag_oe_out,
  input wire logic slave_reply_n_in,
  // System control, received; bus initialize driven
  input wire logic halt_request_n_in,
  input wire logic external_event_line_n_in,
  input wire logic dc_power_good_n_in,
  input wire logic ac_power_good_n_in,
  output logic bus_initialize_n_out,
  output logic bus_initialize_oe_out,
  // Interrupt and DMA chains
  input wire logic [bpbus_pkg::IRQ_W-1:0] int_request_n_in,
  output logic int_ack_chain_out_n_out,
  input wire logic irq_ack_in,
  input wire logic dma_request_n_in,
  input wire logic dma_select_ack_n_in,
  output logic dma_grant_chain_out_n_out,
  output logic dma_active_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 7 + IRQ_W;  // Power-good pin sits on top
  logic [NSYNC-1:0] pin_raw;    // Raw asynchronous pins
  logic [NSYNC-1:0] s1_q;       // First stage, read by s2 only
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] stab_q;     // Accepted levels
  logic [NSYNC-1:0] stab_d;
  logic [DATA_W-1:0] rd1_q;     // Read data capture stages
  logic [DATA_W-1:0] rd2_q;

  assign pin_raw = {ac_power_good_n_in, int_request_n_in, dma_request_n_in,
                    dma_select_ack_n_in, halt_request_n_in,
                    external_event_line_n_in, dc_power_good_n_in,
                    slave_reply_n_in};

  // Accept a change only when stages two and three agree
  always_comb
  begin
    for (int i = 0; i < NSYNC; i++)
    begin
      stab_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stab_q[i];
    end
  end

  // Idle level is negated high, so pin stages reset to all ones
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      stab_q <= '1;
      rd1_q <= '0;
      rd2_q <= '0;
    end
    else
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stab_q <= stab_d;
      rd1_q <= ~mux_addr_data_line_n_in[DATA_W-1:0];
      rd2_q <= rd1_q;
    end
  end

  // Active-high views of the accepted levels
  logic reply;
  logic dma_req;
  logic dma_sack;
  logic [IRQ_W-1:0] irq_req;
  logic halt_req;
  assign reply = ~stab_q[0];
  assign halt_req = ~stab_q[3];
  assign dma_sack = ~stab_q[4];
  assign dma_req = ~stab_q[5];
  assign irq_req = ~stab_q[NSYNC-2:6];

  // ----------------------------------------------------------------
  // Cycle engine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle, st_addr, st_strobe, st_wait_rel, st_release
  } eng_state_e;

  // Is this kind a read in its first data phase
  function automatic logic kind_reads(input cycle_kind_e k);
    return (k == word_read_cycle) || (k == rmw_word_cycle) ||
           (k == rmw_byte_cycle) || (k == block_read_cycle);
  endfunction

  // Does this kind go on with a write phase after the read
  function automatic logic kind_rmw(input cycle_kind_e k);
    return (k == rmw_word_cycle) || (k == rmw_byte_cycle);
  endfunction

  eng_state_e st_q, st_d;
  cycle_kind_e kind_q, kind_d;
  logic rmw_wr_q, rmw_wr_d;           // In write half of rmw
  logic last_q, last_d;               // Final word of a block
  logic [ADDR_W-1:0] ad_q, ad_d;      // Value on address/data lines
  logic [ADDR_W-1:0] adoe_q, adoe_d;
  logic sync_q, sync_d;
  logic din_q, din_d;
  logic dout_q, dout_d;
  logic wtbt_q, wtbt_d;
  logic bs7_q, bs7_d;
  logic blk_q, blk_d;
  logic [TMO_W-1:0] tmo_q, tmo_d;
  logic rdv_q, rdv_d;
  logic [DATA_W-1:0] rdat_q, rdat_d;
  logic done_q, done_d;
  logic terr_q, terr_d;
  logic rdy_q, rdy_d;
  logic timed_out;
  logic dma_active_q, dma_active_d;   // A DMA device holds the bus

  // Timer runs from cycle start; reaching the limit aborts
  // The limit is a parameter so it can exceed slow slaves
  assign timed_out = (tmo_q >= TMO_W'(TIMEOUT_CYCLES));

  always_comb
  begin
    st_d = st_q;
    kind_d = kind_q;
    rmw_wr_d = rmw_wr_q;
    last_d = last_q;
    ad_d = ad_q;
    adoe_d = adoe_q;
    sync_d = sync_q;
    din_d = din_q;
    dout_d = dout_q;
    wtbt_d = wtbt_q;
    bs7_d = bs7_q;
    blk_d = blk_q;
    tmo_d = (st_q == st_idle) ? '0 : tmo_q + TMO_W'(1);
    rdv_d = 1'b0;
    rdat_d = rdat_q;
    done_d = 1'b0;
    terr_d = terr_q;
    rdy_d = 1'b0;
    case (st_q)
      // Only the master starts a cycle, and only while no DMA device holds the bus
      st_idle:
      begin
        rdy_d = ~dma_active_q;
        if (req_valid_in && rdy_q && !dma_active_q)
        begin
          kind_d = req_kind_in;
          rmw_wr_d = 1'b0;
          last_d = req_last_in;
          ad_d = req_addr_in;
          adoe_d = '1;
          wtbt_d = !kind_reads(req_kind_in);
          bs7_d = &req_addr_in[ADDR_W-1:13];
          terr_d = 1'b0;
          st_d = st_addr;
        end
      end
      // Address is on the lines; assert sync and hold it
      st_addr:
      begin
        sync_d = 1'b1;
        st_d = st_strobe;
      end
      // Drop address, raise the data strobe for this phase
      st_strobe:
      begin
        bs7_d = 1'b0;
        blk_d = (kind_q == block_read_cycle) ||
                (kind_q == block_write_cycle);
        if (kind_reads(kind_q) && !rmw_wr_q)
        begin
          adoe_d = '0;
          din_d = 1'b1;
        end
        else
        begin
          ad_d = {{(ADDR_W-DATA_W){1'b0}}, req_wdata_in};
          adoe_d = {{(ADDR_W-DATA_W){1'b0}}, {DATA_W{1'b1}}};
          wtbt_d = (kind_q == byte_write_cycle) ||
                   (kind_q == rmw_byte_cycle);
          dout_d = 1'b1;
        end
        st_d = st_wait_rel;
      end
      // Interlock: stay until the slave's reply has come and gone, or time runs out
      st_wait_rel:
      begin
        if (timed_out)
        begin
          terr_d = 1'b1;
          st_d = st_release;
        end
        else if (reply && (din_q || dout_q))
        begin
          if (din_q)
          begin
            rdat_d = rd2_q;
            rdv_d = 1'b1;
          end
          din_d = 1'b0;
          dout_d = 1'b0;
        end
        else if (!reply && !din_q && !dout_q)
        begin
          // Reply gone; choose the next phase of this cycle
          if (kind_rmw(kind_q) && !rmw_wr_q)
          begin
            rmw_wr_d = 1'b1;
            st_d = st_strobe;
          end
          else if (blk_q && !last_q)
          begin
            last_d = req_last_in;
            st_d = st_strobe;
          end
          else
          begin
            st_d = st_release;
          end
        end
      end
      // Let every driven line float back to negated high
      st_release:
      begin
        sync_d = 1'b0;
        din_d = 1'b0;
        dout_d = 1'b0;
        wtbt_d = 1'b0;
        bs7_d = 1'b0;
        blk_d = 1'b0;
        adoe_d = '0;
        ad_d = '0;
        done_d = 1'b1;
        st_d = st_idle;
      end
      default:
      begin
        st_d = st_idle;
      end
    endcase
  end

  // Engine registers
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= st_idle;
      kind_q <= word_read_cycle;
      rmw_wr_q <= 1'b0;
      last_q <= 1'b0;
      ad_q <= '0;
      adoe_q <= '0;
      sync_q <= 1'b0;
      din_q <= 1'b0;
      dout_q <= 1'b0;
      wtbt_q <= 1'b0;
      bs7_q <= 1'b0;
      blk_q <= 1'b0;
      tmo_q <= '0;
      rdv_q <= 1'b0;
      rdat_q <= '0;
      done_q <= 1'b0;
      terr_q <= 1'b0;
      rdy_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      kind_q <= kind_d;
      rmw_wr_q <= rmw_wr_d;
      last_q <= last_d;
      ad_q <= ad_d;
      adoe_q <= adoe_d;
      sync_q <= sync_d;
      din_q <= din_d;
      dout_q <= dout_d;
      wtbt_q <= wtbt_d;
      bs7_q <= bs7_d;
      blk_q <= blk_d;
      tmo_q <= tmo_d;
      rdv_q <= rdv_d;
      rdat_q <= rdat_d;
      done_q <= done_d;
      terr_q <= terr_d;
      rdy_q <= rdy_d;
    end
  end

  // ----------------------------------------------------------------
  // Arbiter and chain sources
  // ----------------------------------------------------------------
  // Grants are given only while our own engine is idle, but only a DMA select ack
  // holds off our cycles; DMA beats interrupts unless a core request is up.
  logic [1:0] grant_q, grant_d;
  logic irqp_q, irqp_d;               // Registered pending view
  logic iak_q, iak_d;
  logic dmg_q, dmg_d;
  logic init_q, init_d;

  always_comb
  begin
    grant_d = grant_q;
    dma_active_d = dma_active_q;
    case (grant_q)
      GRANT_NONE:
      begin
        if (st_q == st_idle && !req_valid_in && dma_req)
        begin
          grant_d = GRANT_DMA;
        end
        else if (st_q == st_idle && irq_ack_in && |irq_req)
        begin
          grant_d = GRANT_IRQ;
        end
      end
      GRANT_DMA:
      begin
        // Selected device takes over; hold off our cycles
        if (dma_sack)
        begin
          dma_active_d = 1'b1;
        end
        else if (dma_active_q || !dma_req)
        begin
          dma_active_d = 1'b0;
          grant_d = GRANT_NONE;
        end
      end
      GRANT_IRQ:
      begin
        if (!irq_ack_in)
        begin
          grant_d = GRANT_NONE;
        end
      end
      default:
      begin
        grant_d = GRANT_NONE;
      end
    endcase
    // Chains leave from our output pins only
    iak_d = (grant_d == GRANT_IRQ);
    dmg_d = (grant_d == GRANT_DMA) && !dma_sack && !dma_active_d;
    // Initialize while either supply still reads not good (line high)
    init_d = stab_q[1] | stab_q[NSYNC-1];
    // Pending interrupt, masked while a halt is requested
    irqp_d = |irq_req & ~halt_req;
  end

  // Arbiter registers
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      grant_q <= GRANT_NONE;
      dma_active_q <= 1'b0;
      iak_q <= 1'b0;
      dmg_q <= 1'b0;
      init_q <= 1'b1;
      irqp_q <= 1'b0;
    end
    else
    begin
      grant_q <= grant_d;
      dma_active_q <= dma_active_d;
      iak_q <= iak_d;
      dmg_q <= dmg_d;
      init_q <= init_d;
      irqp_q <= irqp_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs: low when asserted, enable only while driving
  // ----------------------------------------------------------------
  assign mux_addr_data_line_n_out = ~ad_q;
  assign mux_addr_data_line_oe_out = adoe_q & ad_q;
  assign cycle_sync_n_out = ~sync_q;
  assign cycle_sync_oe_out = sync_q;
  assign data_in_strobe_n_out = ~din_q;
  assign data_in_strobe_oe_out = din_q;
  assign data_out_strobe_n_out = ~dout_q;
  assign data_out_strobe_oe_out = dout_q;
  assign write_byte_flag_n_out = ~wtbt_q;
  assign write_byte_flag_oe_out = wtbt_q;
  assign io_page_select_n_out = ~bs7_q;
  assign io_page_select_oe_out = bs7_q;
  assign refresh_or_block_flag_n_out = ~blk_q;
  assign refresh_or_block_flag_oe_out = blk_q;
  assign bus_initialize_n_out = ~init_q;
  assign bus_initialize_oe_out = init_q;
  assign int_ack_chain_out_n_out = ~iak_q;
  assign dma_grant_chain_out_n_out = ~dmg_q;
  assign dma_active_out = dma_active_q;
  assign req_ready_out = rdy_q;
  assign rdata_valid_out = rdv_q;
  assign rdata_out = rdat_q;
  assign done_out = done_q;
  assign timeout_err_out = terr_q;
  assign irq_pending_out = irqp_q;

endmodule

// >>> hdl/bpbus_pkg.sv
// Constants shared by the backplane bus master port
package bpbus_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 22;        // Full physical address width
  localparam int DATA_W = 16;        // Multiplexed address/data part
  localparam int IRQ_W = 4;          // Interrupt request levels 4..7
  localparam int DMA_REQ_W = 4;      // Internal DMA requester count

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;         // Core clock rate
  localparam int TIMEOUT_NS = 10_000;         // No-reply limit, 10 us
  // Longest time rounds down to whole microseconds before scaling to cycles
  localparam int TIMEOUT_CYC = (TIMEOUT_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int TMO_W = 10;                  // Timeout counter width
  localparam int SYNC_STAGES = 3;             // Pin input synchroniser

  // ----------------------------------------------------------------
  // Cycle kinds requested by the core
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    word_read_cycle,
    word_write_cycle,
    byte_write_cycle,
    rmw_word_cycle,
    rmw_byte_cycle,
    block_read_cycle,
    block_write_cycle
  } cycle_kind_e;

  // Arbitration grant holder codes
  localparam logic [1:0] GRANT_NONE = 2'h0;
  localparam logic [1:0] GRANT_IRQ = 2'h1;
  localparam logic [1:0] GRANT_DMA = 2'h2;

endpackage

// >>> test/backplane_bus_master_port_props.sv
// Concurrent checks on the backplane bus master port pins
module backplane_bus_master_port_props
#(
  parameter int TIMEOUT_CYCLES = 500   // Reply limit handed on by bind
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic req_ready_out,
  input wire logic done_out,
  input wire logic timeout_err_out,
  input wire logic [21:0] mux_addr_data_line_oe_out,
  input wire logic cycle_sync_n_out,
  input wire logic cycle_sync_oe_out,
  input wire logic data_in_strobe_n_out,
  input wire logic data_in_strobe_oe_out,
  input wire logic data_out_strobe_n_out,
  input wire logic data_out_strobe_oe_out,
  input wire logic int_ack_chain_out_n_out,
  input wire logic dma_grant_chain_out_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  // A line counts as asserted only while driven low
  logic sync_on;
  logic din_on;
  logic dout_on;
  logic [15:0] sync_cnt_q;  // Consecutive cycles with sync held
  logic [15:0] sync_cnt_d;
  // Slack covers start-up and release, so slow replies never trip it
  localparam int SYNC_LIM = TIMEOUT_CYCLES + 4;
  assign sync_on = cycle_sync_oe_out && !cycle_sync_n_out;
  assign din_on = data_in_strobe_oe_out && !data_in_strobe_n_out;
  assign dout_on = data_out_strobe_oe_out && !data_out_strobe_n_out;

  // Next count: grows while sync holds, clears otherwise
  always_comb
  begin
    sync_cnt_d = sync_on ? sync_cnt_q + 16'h0001 : 16'h0000;
  end

  // Count register
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      sync_cnt_q <= 16'h0000;
    else
      sync_cnt_q <= sync_cnt_d;
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_din_in_cycle: assert property (din_on |-> sync_on)
    else $error("input strobe outside a cycle");
  a_dout_in_cycle: assert property (dout_on |-> sync_on)
    else $error("output strobe outside a cycle");
  a_one_strobe: assert property (!(din_on && dout_on))
    else $error("both strobes asserted");
  a_sync_bounded: assert property (sync_cnt_q <= SYNC_LIM)
    else $error("cycle held past the reply limit");
  a_abort_releases: assert property ($rose(timeout_err_out) |->
    ##[0:4] (!cycle_sync_oe_out && mux_addr_data_line_oe_out == '0))
    else $error("lines not released after abort");
  a_done_pulse: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  a_ready_after_done: assert property (done_out |->
    ##[1:2] req_ready_out)
    else $error("ready not back after done");
  a_idle_quiet: assert property (req_ready_out |->
    !(din_on || dout_on))
    else $error("strobe while idle");
  a_sync_low_only: assert property (cycle_sync_oe_out |->
    !cycle_sync_n_out)
    else $error("sync driven high");
  a_chains_apart: assert property (!(!int_ack_chain_out_n_out &&
    !dma_grant_chain_out_n_out))
    else $error("ack and grant chains together");
endmodule

bind backplane_bus_master_port backplane_bus_master_port_props
#(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
)
u_props
(
  .core_clk_in(core_clk_in),
  .rst_in(rst_in),
  .req_ready_out(req_ready_out),
  .done_out(done_out),
  .timeout_err_out(timeout_err_out),
  .mux_addr_data_line_oe_out(mux_addr_data_line_oe_out),
  .cycle_sync_n_out(cycle_sync_n_out),
  .cycle_sync_oe_out(cycle_sync_oe_out),
  .data_in_strobe_n_out(data_in_strobe_n_out),
  .data_in_strobe_oe_out(data_in_strobe_oe_out),
  .data_out_strobe_n_out(data_out_strobe_n_out),
  .data_out_strobe_oe_out(data_out_strobe_oe_out),
  .int_ack_chain_out_n_out(int_ack_chain_out_n_out),
  .dma_grant_chain_out_n_out(dma_grant_chain_out_n_out)
);

// >>> test/bp_slave_model.sv
// Behavioural memory slave answering on the backplane lines
module bp_slave_model
#(
  parameter logic [15:0] RD = 16'hA5C3   // Word returned on reads
)
(
  input wire logic clk_in,
  input wire logic sync_n_in,            // Resolved line levels
  input wire logic din_n_in,
  input wire logic dout_n_in,
  input wire logic bs7_n_in,
  input wire logic [21:0] line_n_in,
  input wire logic mute_in,              // Never reply when set
  input wire logic [7:0] dly_in,         // Reply latency in cycles
  output logic reply_n_out,
  output logic [21:0] pull_out,          // Bits pulled low
  output logic [21:0] addr_out,
  output logic [15:0] wdata_out,
  output logic iopage_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sync_q;
  logic [7:0] cnt;
  initial
  begin
    reply_n_out = 1'h1;
    pull_out = 22'h00_0000;
    sync_q = 1'h1;
    cnt = 8'h00;
  end

  // Latch the full address as the cycle opens
  always @(posedge clk_in)
  begin
    sync_q <= sync_n_in;
    if (sync_q && !sync_n_in)
    begin
      addr_out <= ~line_n_in;
      iopage_out <= !bs7_n_in;
    end
  end

  // Reply after the latency; release lines once the strobe drops
  always @(posedge clk_in)
  begin
    if (!sync_n_in && (!din_n_in || !dout_n_in))
    begin
      if (cnt < dly_in)
        cnt <= cnt + 8'h01;
      else if (!mute_in)
      begin
        reply_n_out <= 1'h0;
        if (!din_n_in)
          pull_out <= {6'h00, RD};
        else
          wdata_out <= ~line_n_in[15:0];
      end
    end
    else
    begin
      // Released lines float back to the pull-up level
      reply_n_out <= 1'h1;
      pull_out <= 22'h00_0000;
      cnt <= 8'h00;
    end
  end
endmodule

// >>> test/backplane_bus_master_port_tb.sv
// Self-checking bench for the backplane bus master port
module backplane_bus_master_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bpbus_pkg::*;
  localparam int TMO = 40;                // Short reply limit
  localparam logic [15:0] RD = 16'hA5C3;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic vld = 1'h0;
  logic irq_ack = 1'h0;
  logic halt_n = 1'h1;
  logic wb_oe, wb_seen;
  logic dmr_n = 1'h1;
  logic sack_n = 1'h1;
  logic mute = 1'h0;
  logic [7:0] dly = 8'h00;
  logic [3:0] irq_n = 4'hF;
  cycle_kind_e kind = word_read_cycle;
  logic [21:0] addr = 22'h00_0000;
  logic [15:0] wd = 16'h0000;
  logic rdy, rdv, done, tmo_err, irq_p, sync_n, sync_oe, din_n, din_oe;
  logic dout_n, dout_oe, bs_n, bs_oe, iak_n, dmg_n, dma_act, init_oe;
  logic s_iop, reply_n, rd_seen;
  logic [15:0] rdata, s_wd, got;
  logic [21:0] l_n, l_oe, pull, s_addr;
  // Open-collector wire: low when any party pulls
  wire logic [21:0] line = ~((l_oe & ~l_n) | pull);
  int bad_count = 0;
  int checks = 0;
  int cyc;

  always #10 clk = ~clk;

  backplane_bus_master_port #(.TIMEOUT_CYCLES(TMO)) dut (
    .core_clk_in(clk), .rst_in(rst), .req_valid_in(vld),
    .req_kind_in(kind), .req_addr_in(addr), .req_wdata_in(wd),
    .req_byte_hi_in(1'h0), .req_last_in(1'h1), .req_ready_out(rdy),
    .rdata_valid_out(rdv), .rdata_out(rdata), .done_out(done),
    .timeout_err_out(tmo_err), .irq_pending_out(irq_p),
    .mux_addr_data_line_n_in(line), .mux_addr_data_line_n_out(l_n),
    .mux_addr_data_line_oe_out(l_oe), .cycle_sync_n_out(sync_n),
    .cycle_sync_oe_out(sync_oe), .data_in_strobe_n_out(din_n),
    .data_in_strobe_oe_out(din_oe), .data_out_strobe_n_out(dout_n),
    .data_out_strobe_oe_out(dout_oe), .write_byte_flag_n_out(),
    .write_byte_flag_oe_out(wb_oe), .io_page_select_n_out(bs_n),
    .io_page_select_oe_out(bs_oe), .refresh_or_block_flag_n_out(),
    .refresh_or_block_flag_oe_out(), .slave_reply_n_in(reply_n),
    .halt_request_n_in(halt_n), .external_event_line_n_in(1'h1),
    .dc_power_good_n_in(1'h0), .ac_power_good_n_in(1'h0),
    .bus_initialize_n_out(), .bus_initialize_oe_out(init_oe),
    .int_request_n_in(irq_n), .int_ack_chain_out_n_out(iak_n),
    .irq_ack_in(irq_ack), .dma_request_n_in(dmr_n),
    .dma_select_ack_n_in(sack_n), .dma_grant_chain_out_n_out(dmg_n),
    .dma_active_out(dma_act));

  bp_slave_model #(.RD(RD)) slave (
    .clk_in(clk), .sync_n_in(~(sync_oe & ~sync_n)),
    .din_n_in(~(din_oe & ~din_n)), .dout_n_in(~(dout_oe & ~dout_n)),
    .bs7_n_in(~(bs_oe & ~bs_n)), .line_n_in(line), .mute_in(mute),
    .dly_in(dly), .reply_n_out(reply_n), .pull_out(pull),
    .addr_out(s_addr), .wdata_out(s_wd), .iopage_out(s_iop));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic bad(input string m);
    bad_count++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask

  task automatic chk_vec(input logic [21:0] g, input logic [21:0] e,
                         input string m);
    checks++;
    if (g !== e)
      bad(m);
  endtask

  // A wait that runs out ends the run at once
  task automatic hung(input int n, input int lim);
    if (n >= lim)
    begin
      bad("wait ran out");
      print_verdict();
    end
  endtask

  // One request from hand-off to done, noting any read data
  task automatic xfer(input cycle_kind_e k, input logic [21:0] a,
                      input logic [15:0] w);
    int n;
    n = 0;
    cyc = 0;
    rd_seen = 1'h0;
    wb_seen = 1'h0;
    kind <= k;
    addr <= a;
    wd <= w;
    vld <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'h1 && n < 50);
    vld <= 1'h0;
    while (done !== 1'h1 && n < 400)
    begin
      @(posedge clk);
      n++;
      cyc++;
      if (dout_oe === 1'h1 && wb_oe === 1'h1)
        wb_seen = 1'h1;
      if (rdv === 1'h1)
      begin
        rd_seen = 1'h1;
        got = rdata;
      end
    end
    hung(n, 400);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    int n;
    repeat (2) @(posedge clk);
    chk_vec(rdy, 1'h0, "ready in reset");
    chk_vec({iak_n, dmg_n}, 2'h3, "chains in reset");
    chk_vec({sync_oe, init_oe}, 2'h1, "lines in reset");
    rst <= 1'h0;
    n = 0;
    while (rdy !== 1'h1 && n < 10)
    begin
      @(posedge clk);
      n++;
    end
    hung(n, 10);
    $display("test reset done");
  endtask

  // Every cycle kind once, alternating in and out of the I/O page
  task automatic t_kinds;
    cycle_kind_e k;
    logic [21:0] a;
    logic [15:0] w;
    logic [15:0] m;
    for (int i = 0; i < 7; i++)
    begin
      k = cycle_kind_e'(i);
      a = ((i % 2) ? 22'h1F_E000 : 22'h3F_E000) | 22'(i * 4);
      w = 16'h5A00 | 16'(i);
      m = (k == byte_write_cycle || k == rmw_byte_cycle) ? 16'h00FF
                                                         : 16'hFFFF;
      xfer(k, a, w);
      chk_vec(tmo_err, 1'h0, "unexpected timeout");
      chk_vec(s_addr, a, "address seen by slave");
      chk_vec(s_iop, (i % 2) == 0, "io page select");
      if (k inside {word_read_cycle, rmw_word_cycle, rmw_byte_cycle,
                    block_read_cycle})
        chk_vec({rd_seen, got}, {1'h1, RD}, "read data");
      if (k != word_read_cycle && k != block_read_cycle)
        chk_vec(s_wd & m, w & m, "write data");
      chk_vec(wb_seen, m == 16'h00FF, "byte flag in data phase");
    end
    chk_vec(init_oe, 1'h0, "init with power good");
    $display("test kinds done");
  endtask

  task automatic t_timeout;
    mute <= 1'h1;
    xfer(word_read_cycle, 22'h00_0100, 16'h0000);
    chk_vec(tmo_err, 1'h1, "no timeout flag");
    chk_vec(cyc >= TMO, 1'h1, "aborted too early");
    chk_vec(rd_seen, 1'h0, "data without reply");
    mute <= 1'h0;
    xfer(word_read_cycle, 22'h00_0100, 16'h0000);
    chk_vec(tmo_err, 1'h0, "flag not cleared");
    $display("test timeout done");
  endtask

  task automatic t_slow;
    dly <= 8'h14;
    xfer(word_read_cycle, 22'h2A_5554, 16'h0000);
    chk_vec(tmo_err, 1'h0, "slow reply aborted");
    chk_vec({rd_seen, got}, {1'h1, RD}, "slow read data");
    chk_vec(cyc > 20, 1'h1, "ended before reply");
    dly <= 8'h00;
    $display("test slow done");
  endtask

  task automatic t_dma;
    int n;
    dmr_n <= 1'h0;
    n = 0;
    while (dmg_n !== 1'h0 && n < 30)
    begin
      @(posedge clk);
      n++;
    end
    hung(n, 30);
    chk_vec(iak_n, 1'h1, "ack chain with grant");
    sack_n <= 1'h0;
    dmr_n <= 1'h1;
    repeat (8) @(posedge clk);
    chk_vec({dma_act, rdy}, 2'h2, "dma mastership");
    sack_n <= 1'h1;
    n = 0;
    while (rdy !== 1'h1 && n < 30)
    begin
      @(posedge clk);
      n++;
    end
    hung(n, 30);
    chk_vec(dma_act, 1'h0, "dma not ended");
    $display("test dma done");
  endtask

  task automatic t_irq;
    int n;
    irq_n <= 4'hE;
    repeat (8) @(posedge clk);
    chk_vec(irq_p, 1'h1, "interrupt not seen");
    halt_n <= 1'h0;
    repeat (8) @(posedge clk);
    chk_vec(irq_p, 1'h0, "pending during halt");
    halt_n <= 1'h1;
    repeat (8) @(posedge clk);
    irq_ack <= 1'h1;
    n = 0;
    while (iak_n !== 1'h0 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    hung(n, 60);
    chk_vec(dmg_n, 1'h1, "grant with ack chain");
    irq_ack <= 1'h0;
    irq_n <= 4'hF;
    n = 0;
    while (rdy !== 1'h1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    hung(n, 100);
    $display("test irq done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    t_reset();
    t_kinds();
    t_timeout();
    t_slow();
    t_dma();
    t_irq();
    print_verdict();
  end
endmodule
